//--- common/acs_pkg.sv
package acs_pkg;

   // ----------------------------------------
   // Register map and field layout
   // ----------------------------------------
   localparam logic [7:0] ACS_ADDR_CONTROL = 8'haa;
   localparam logic [7:0] ACS_ADDR_CONFIG = 8'hab;
   localparam logic [7:0] ACS_ADDR_CHANNEL = 8'hac;
   localparam logic [7:0] ACS_ADDR_RESULT = 8'had;
   localparam logic [7:0] ACS_RST_CONTROL = 8'h00;
   localparam logic [7:0] ACS_RST_CONFIG = 8'hf8;
   localparam logic [7:0] ACS_RST_CHANNEL = 8'h00;
   localparam logic [7:0] ACS_RST_RESULT = 8'h00;
   localparam int ACS_BIT_ENABLE = 7;
   localparam int ACS_BIT_TRACK = 6;
   localparam int ACS_BIT_DONE = 5;
   localparam int ACS_BIT_BUSY = 4;
   localparam int ACS_SRC_LSB = 1;
   localparam int ACS_DIV_LSB = 3;
   localparam logic [7:0] ACS_CONTROL_MASK = 8'hfe;
   localparam logic [7:0] ACS_CONFIG_MASK = 8'hfb;
   localparam logic [7:0] ACS_CHANNEL_MASK = 8'h07;

   // ----------------------------------------
   // Start sources and timing
   // ----------------------------------------
   localparam logic [2:0] ACS_SRC_SOFT = 3'h0;
   localparam logic [2:0] ACS_SRC_TIMER3 = 3'h1;
   localparam logic [2:0] ACS_SRC_PIN = 3'h2;
   localparam logic [2:0] ACS_SRC_TIMER2 = 3'h3;
   localparam logic [3:0] ACS_TRACK_PERIODS = 4'h3;
   localparam logic [3:0] ACS_CONVERT_PERIODS = 4'h8;

   typedef enum logic [1:0] {
      ACS_IDLE = 2'b00,
      ACS_TRACK = 2'b01,
      ACS_CONVERT = 2'b11
   } acs_state_e;

   // Register bus request.
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } acs_req_s;

   // Trigger event sources.
   typedef struct packed {
      logic timer3_overflow;
      logic timer2_overflow;
      logic companion_converter_busy;
   } acs_trig_s;

endpackage

//--- hw/acs_sequencer.sv
`timescale 1ns/1ns
// How it works
// - Conversion clock is core clock divided by divider field plus one.
// - Two-bit gain field selects gain 0.5, 1, 2 or 4.
// - Config bit 2 reads zero; writes ignored.
// - Channel field in low three bits picks one of eight inputs.
// - Enable zero holds shutdown; one makes converter active for triggers.
// - Track mode zero and enabled: track continuously except during conversion.
// - Done flag set on completion, cleared only by software writing zero.
// - Done flag sets when busy falls at end of conversion.
// - Busy reads one while a conversion is in progress.
// - Writing one to busy starts conversion only when source is 000.
// - Start source selects software, timer 3, pin edge, timer 2 or companion.
// - Low-power mode: trigger starts three-period tracking, then conversion.
// - Low-power pin mode: track while pin low, convert on rising edge.
// - Conversion takes eight conversion-clock periods before busy releases.
// - Result is unsigned straight binary from the analog converter.
// - Control bit 0 reads zero; writes ignored.
// - Busy falling at end of conversion raises interrupt request when interrupt enabled.
module acs_sequencer (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Register access
   input wire acs_pkg::acs_req_s req,
   output logic [7:0] rdata,
   // Trigger sources
   input wire acs_pkg::acs_trig_s trig,
   input wire logic external_convert_start,
   input wire logic interrupt_enable,
   // Analog front end
   input wire logic [7:0] sar_sample_code,
   output logic [2:0] input_channel_field,
   output logic [1:0] pga_gain_select,
   output logic converter_powered,
   output logic track_active,
   output logic conversion_clock,
   output logic interrupt_request
);
   import acs_pkg::*;

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [7:0] control_reg, control_next;
   logic [7:0] config_reg, config_next;
   logic [7:0] channel_reg, channel_next;
   logic [7:0] result_reg, result_next;
   logic [4:0] div_cnt_reg, div_cnt_next;
   logic [3:0] period_reg, period_next;
   acs_state_e state_reg, state_next;
   logic pin_meta_reg, pin_sync_reg, pin_last_reg;
   logic irq_reg, irq_next;
   logic sclk_reg, sclk_next;

   function automatic logic is_write(input acs_req_s r, input logic [7:0] a);
      is_write = r.wr && (r.addr == a);
   endfunction

   // ----------------------------------------
   // Decoding
   // ----------------------------------------
   wire logic enabled = control_reg[ACS_BIT_ENABLE];
   wire logic low_power = control_reg[ACS_BIT_TRACK];
   wire logic [2:0] source = control_reg[ACS_SRC_LSB +: 3];
   wire logic [4:0] divider = config_reg[ACS_DIV_LSB +: 5];
   wire logic ctl_wr = is_write(req, ACS_ADDR_CONTROL);
   wire logic sar_tick = (div_cnt_reg == divider);
   wire logic pin_rise = pin_sync_reg && !pin_last_reg;
   wire logic idle = (state_reg == ACS_IDLE);
   wire logic soft_start = ctl_wr && req.wdata[ACS_BIT_BUSY] && (source == ACS_SRC_SOFT);
   wire logic trigger = source[2] ? trig.companion_converter_busy :
                        (source == ACS_SRC_SOFT) ? soft_start :
                        (source == ACS_SRC_TIMER3) ? trig.timer3_overflow :
                        (source == ACS_SRC_PIN) ? pin_rise : trig.timer2_overflow;
   // Triggers only taken when idle and enabled.
   wire logic accept = trigger && idle && enabled;
   wire logic pin_mode = (source == ACS_SRC_PIN);
   wire logic finish = (state_reg == ACS_CONVERT) && sar_tick && (period_reg == 4'h1);

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      state_next = state_reg;
      period_next = period_reg;
      result_next = result_reg;
      irq_next = 1'b0;
      case (state_reg)
         ACS_IDLE: begin
            if (accept) begin
               // Tracking window first in low-power mode, except with the pin source.
               if (low_power && !pin_mode) begin
                  state_next = ACS_TRACK;
                  period_next = ACS_TRACK_PERIODS;
               end else begin
                  // Normal mode, or a pin edge in low-power mode, goes straight to conversion.
                  state_next = ACS_CONVERT;
                  period_next = ACS_CONVERT_PERIODS;
               end
            end
         end
         ACS_TRACK: begin
            if (sar_tick) begin
               if (period_reg == 4'h1) begin
                  state_next = ACS_CONVERT;
                  period_next = ACS_CONVERT_PERIODS;
               end else begin
                  period_next = period_reg - 4'h1;
               end
            end
         end
         ACS_CONVERT: begin
            if (sar_tick) begin
               if (finish) begin
                  state_next = ACS_IDLE;
                  // Straight binary code from the converter.
                  result_next = sar_sample_code;
                  irq_next = interrupt_enable;
               end else begin
                  period_next = period_reg - 4'h1;
               end
            end
         end
         default: begin
            state_next = ACS_IDLE;
         end
      endcase
      if (!enabled) begin
         state_next = ACS_IDLE;
         irq_next = 1'b0;
      end
   end

   always_comb begin
      control_next = control_reg;
      if (ctl_wr) begin
         control_next = req.wdata & ACS_CONTROL_MASK;
         // Done flag only cleared by software; writing one keeps it.
         control_next[ACS_BIT_DONE] = control_reg[ACS_BIT_DONE] & req.wdata[ACS_BIT_DONE];
      end
      // Done sets on busy fall, winning over a clear.
      if (finish && enabled) begin
         control_next[ACS_BIT_DONE] = 1'b1;
      end
      control_next[ACS_BIT_BUSY] = (state_next != ACS_IDLE);
   end

   assign config_next = is_write(req, ACS_ADDR_CONFIG) ? (req.wdata & ACS_CONFIG_MASK) : config_reg;
   // Only the low three bits kept.
   assign channel_next = is_write(req, ACS_ADDR_CHANNEL) ? (req.wdata & ACS_CHANNEL_MASK) : channel_reg;
   assign div_cnt_next = sar_tick ? 5'h00 : div_cnt_reg + 5'h01;
   assign sclk_next = (div_cnt_next <= {1'b0, divider[4:1]});

   // ----------------------------------------
   // Flip-flops
   // ----------------------------------------
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         control_reg <= ACS_RST_CONTROL;
         config_reg <= ACS_RST_CONFIG;
         channel_reg <= ACS_RST_CHANNEL;
         result_reg <= ACS_RST_RESULT;
      end else begin
         control_reg <= control_next;
         config_reg <= config_next;
         channel_reg <= channel_next;
         result_reg <= result_next;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_reg <= ACS_IDLE;
         period_reg <= 4'h0;
         div_cnt_reg <= 5'h00;
         irq_reg <= 1'b0;
         sclk_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         period_reg <= period_next;
         div_cnt_reg <= div_cnt_next;
         irq_reg <= irq_next;
         sclk_reg <= sclk_next;
      end
   end

   // The pin is asynchronous, so it passes two flops before edge detection.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pin_meta_reg <= 1'b0;
         pin_sync_reg <= 1'b0;
         pin_last_reg <= 1'b0;
      end else begin
         pin_meta_reg <= external_convert_start;
         pin_sync_reg <= pin_meta_reg;
         pin_last_reg <= pin_sync_reg;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Reads are combinational so software sees the current flag state.
   assign rdata = (req.addr == ACS_ADDR_CONTROL) ? control_reg :
                  (req.addr == ACS_ADDR_CONFIG) ? config_reg :
                  (req.addr == ACS_ADDR_CHANNEL) ? channel_reg :
                  (req.addr == ACS_ADDR_RESULT) ? result_reg : 8'h00;
   // Gain code passed to the amplifier.
   assign pga_gain_select = config_reg[1:0];
   assign input_channel_field = channel_reg[2:0];
   assign converter_powered = enabled;
   // Normal mode tracks whenever not converting.
   // Low-power pin mode tracks while pin is low.
   assign track_active = enabled && (state_reg != ACS_CONVERT) &&
                         (!low_power ? 1'b1 : pin_mode ? !pin_sync_reg : (state_reg == ACS_TRACK));
   assign conversion_clock = sclk_reg;
   assign interrupt_request = irq_reg;

endmodule

//--- testbench/acs_checker.sv
`timescale 1ns/1ns
// ------------------------------
// Port checks
// ------------------------------
module acs_checker
   import acs_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Watched ports
   input wire acs_pkg::acs_req_s req,
   input wire logic [7:0] rdata,
   input wire logic interrupt_enable,
   input wire logic [2:0] input_channel_field,
   input wire logic [1:0] pga_gain_select,
   input wire logic converter_powered,
   input wire logic track_active,
   input wire logic interrupt_request
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   wire a_ctl = req.addr == ACS_ADDR_CONTROL;
   wire a_cfg = req.addr == ACS_ADDR_CONFIG;
   wire a_chn = req.addr == ACS_ADDR_CHANNEL;
   ctl_unused_a: assert property (a_ctl |-> !rdata[0])
      else $error("control bit 0 reads one");
   cfg_unused_a: assert property (a_cfg |-> !rdata[2])
      else $error("config bit 2 reads one");
   chan_field_a: assert property (a_chn |-> rdata[7:3] == 5'h00 && input_channel_field == rdata[2:0])
      else $error("channel field wrong");
   gain_out_a: assert property (a_cfg |-> pga_gain_select == rdata[1:0])
      else $error("gain output differs from config");
   power_bit_a: assert property (a_ctl |-> converter_powered == rdata[7])
      else $error("power output differs from enable");
   track_off_a: assert property (!converter_powered |-> !track_active)
      else $error("tracking while shut down");
   done_sticky_a: assert property (a_ctl && rdata[5] && !req.wr ##1 a_ctl |-> rdata[5])
      else $error("done flag cleared by hardware");
   irq_gate_a: assert property (!interrupt_enable [*2] |-> !interrupt_request)
      else $error("interrupt while disabled");
   irq_pulse_a: assert property (interrupt_request |=> !interrupt_request)
      else $error("interrupt longer than one cycle");
   irq_done_a: assert property (interrupt_request && a_ctl |-> rdata[5])
      else $error("interrupt without done flag");
   cover property (interrupt_request);
   cover property (a_ctl && rdata[4]);
   cover property (track_active && converter_powered);
endmodule

bind acs_sequencer acs_checker chk (.clock, .rst, .req, .rdata, .interrupt_enable, .input_channel_field,
   .pga_gain_select, .converter_powered, .track_active, .interrupt_request);

//--- testbench/acs_trigger_model.sv
`timescale 1ns/1ns
// ------------------------------
// Timer, pin and companion trigger sources
// ------------------------------
module acs_trigger_model
   import acs_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Bench command
   input wire logic fire,
   input wire logic [2:0] kind,
   // Trigger outputs
   output acs_pkg::acs_trig_s trig,
   output logic external_convert_start
);
   logic [2:0] hold_reg;
   assign trig.timer3_overflow = fire && kind == ACS_SRC_TIMER3;
   assign trig.timer2_overflow = fire && kind == ACS_SRC_TIMER2;
   assign trig.companion_converter_busy = fire && kind[2];
   assign external_convert_start = hold_reg != 3'h0;
   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         hold_reg <= 3'h0;
      else if (fire && kind == ACS_SRC_PIN)
         hold_reg <= 3'h6;
      else if (hold_reg != 3'h0)
         hold_reg <= hold_reg - 3'h1;
   end
endmodule

//--- testbench/adc8_conversion_sequencer_tb.sv
`timescale 1ns/1ns
`define CHK(n, e, g) cmp_count++; if ((g) !== (e)) begin errors++; $display("BAD %s exp %h got %h", n, e, g); end
// ------------------------------
// Bench
// ------------------------------
module adc8_conversion_sequencer_tb;
   import acs_pkg::*;
   logic clock = 0, rst = 1, fire = 0, interrupt_enable = 0, irq_seen = 0, tmx;
   logic [2:0] kind = 3'h0, input_channel_field;
   logic [1:0] pga_gain_select;
   logic [7:0] sar_sample_code = 8'h00, rdata, v, w, ctl, ev;
   logic [7:0] ra[5] = '{8'haa, 8'hab, 8'hac, 8'had, 8'h55};
   logic [7:0] re[5] = '{8'h00, 8'hf8, 8'h00, 8'h00, 8'h00};
   logic converter_powered, track_active, conversion_clock, interrupt_request, external_convert_start;
   acs_req_s req = '0;
   acs_trig_s trig;
   int errors = 0, cmp_count = 0, cyc = 0, t0, n, p, lo, hi, seed = 32'h0bdf1116, sclk_rises = 0;
   logic sclk_last = 0;
   logic [7:0] exp_q[$];
   acs_sequencer uut (.clock, .rst, .req, .rdata, .trig, .external_convert_start, .interrupt_enable,
      .sar_sample_code, .input_channel_field, .pga_gain_select, .converter_powered, .track_active,
      .conversion_clock, .interrupt_request);
   acs_trigger_model far (.clock, .rst, .fire, .kind, .trig, .external_convert_start);
   always #5 clock = ~clock;
   always @(posedge clock) begin
      cyc++;
      if (conversion_clock && !sclk_last)
         sclk_rises++;
      sclk_last = conversion_clock;
      if (interrupt_request)
         irq_seen = 1;
      if (cyc == 20000) begin
         errors++;
         wrap_up();
      end
   end
   task wrap_up;
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      #1 req.wr = 1;
      req.addr = a;
      req.wdata = d;
      @(posedge clock);
      #1 req.wr = 0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge clock);
      #1 req.addr = a;
      req.rd = 1;
      #6 v = rdata;
   endtask
   task fire_src(input logic [2:0] k);
      // Flag cleared and busy set by the same control write.
      if (k == ACS_SRC_SOFT)
         wr(ACS_ADDR_CONTROL, ctl | 8'h10);
      else begin
         @(posedge clock);
         #1 kind = k;
         fire = 1;
         @(posedge clock);
         #1 fire = 0;
      end
   endtask
   initial begin
      repeat (10) @(posedge clock);
      #1 rst = 0;
      for (int i = 0; i < 5; i++) begin
         rd(ra[i]);
         `CHK("reset value", re[i], v)
      end
      repeat (4) begin
         w = $random(seed);
         wr(ACS_ADDR_CONFIG, w);
         rd(ACS_ADDR_CONFIG);
         `CHK("config", w & 8'hfb, v)
         `CHK("gain", w[1:0], pga_gain_select)
         wr(ACS_ADDR_CHANNEL, w);
         rd(ACS_ADDR_CHANNEL);
         `CHK("channel", w[2:0], input_channel_field)
         ctl = w & 8'h4f;
         wr(ACS_ADDR_CONTROL, ctl);
         fire_src(ACS_SRC_SOFT);
         rd(ACS_ADDR_CONTROL);
         `CHK("control off", w & 8'h4e, v)
      end
      for (int tm = 0; tm < 2; tm++) begin
         for (int s = 0; s < 5; s++) begin
            // Dividing by 17 or more keeps the conversion clock under 6 MHz.
            p = ($random(seed) & 3) + 17;
            tmx = tm == 1 && s != 2;
            wr(ACS_ADDR_CONFIG, {p[4:0] - 5'h01, 3'h0});
            interrupt_enable = s[0];
            ctl = 8'h80 | (tm << 6) | (s << 1);
            wr(ACS_ADDR_CONTROL, ctl);
            fire_src((s + 1) % 5);
            repeat (30) @(posedge clock);
            rd(ACS_ADDR_CONTROL);
            `CHK("wrong source", 2'b00, v[5:4])
            `CHK("track idle", tm == 0 || s == 2, track_active)
            sar_sample_code = $random(seed);
            exp_q.push_back(sar_sample_code);
            irq_seen = 0;
            fire_src(s[2:0]);
            t0 = cyc;
            n = 0;
            do begin
               rd(ACS_ADDR_CONTROL);
               n++;
               if (n == 2)
                  fire_src(s[2:0]);
            end while (!v[5] && cyc - t0 < 400);
            n = cyc - t0;
            lo = (7 + 3 * tmx) * p;
            hi = (8 + 3 * tmx) * p + 8;
            `CHK("duration", 1'b1, n >= lo && n <= hi)
            repeat (2) @(posedge clock);
            #1 `CHK("interrupt", s[0], irq_seen)
            ev = exp_q.pop_front();
            rd(ACS_ADDR_RESULT);
            `CHK("result", ev, v)
            @(posedge clock);
            #1 sclk_rises = 0;
            repeat (4 * p) @(posedge clock);
            #1 `CHK("sar clock", 4, sclk_rises)
            rd(ACS_ADDR_CONTROL);
            `CHK("done kept", 2'b10, v[5:4])
         end
      end
      wrap_up();
   end
endmodule
